// >>> design/gcs_engine.sv
// co-processor graphics state, list control and command flag logic
// assumes a command word stream with valid/ready, a list memory write
// port, a scan-out done pulse and a classic wishbone register slave
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "gcs_params.svh"

module gcs_engine
   import gcs_pkg::*;
#(
   parameter int LIST_AW   = 11,                     // list word address width
   parameter int MS_CYCLES = `GCS_MS_CYCLES          // cycles per millisecond
) (
   input  wire logic               ref_clk,          // system clock
   input  wire logic               rst_b,            // engine reset, active low
   input  wire logic               clk_en,           // freezes all state when low
   // command stream
   input  wire logic [31:0]        cmd_data,         // command word
   input  wire logic               cmd_valid,        // command word present
   output logic                    cmd_ready,        // word taken this cycle
   input  wire logic               fifo_empty,       // no further words queued
   // list memory and scan-out
   output logic [LIST_AW-1:0]      list_addr,        // list memory word address
   output logic [31:0]             list_wdata,       // list memory data
   output logic                    list_we,          // list memory write strobe
   input  wire logic               scan_done,        // current list scanned out
   output logic                    swap_req,         // swap request pulse
   // widget colour query
   input  wire gcs_widget_t        widget,           // widget being drawn
   input  wire gcs_region_t        region,           // region of that widget
   output logic [23:0]             paint_colour,     // colour for that region
   output logic                    paint_used,       // region is coloured
   output logic [4:0]              reserved_handle,  // handle used by widgets
   output logic [3:0]              user_ctx_depth,   // host save depth
   // wishbone
   input  wire logic [7:0]         wb_adr_i,         // byte address
   input  wire logic [31:0]        wb_dat_i,         // write data
   input  wire logic [3:0]         wb_sel_i,         // byte lanes
   input  wire logic               wb_we_i,          // write
   input  wire logic               wb_cyc_i,         // cycle
   input  wire logic               wb_stb_i,         // strobe
   output logic [31:0]             wb_dat_o,         // read data
   output logic                    wb_ack_o,         // acknowledge
   output logic                    irq               // level interrupt
);

   gcs_state_t     state_reg;
   gcs_colours_t   col_reg;
   logic [23:0]    high_reg;
   logic           spin_reg;
   logic [7:0]     track_reg;
   logic [31:0]    mat_a_reg;
   logic [31:0]    mat_e_reg;
   logic [31:0]    op_reg;
   logic [31:0]    ms_left_reg;
   logic [31:0]    tick_reg;
   logic           timer_on_reg;
   logic [11:0]    read_ptr_reg;
   logic [31:0]    skip_reg;
   logic [1:0]     arg_idx_reg;
   logic [LIST_AW-1:0] ofs_reg;
   logic [1:0]     status_reg;
   logic [1:0]     enable_reg;
   logic           ack_reg;
   logic [31:0]    rdat_reg;
   logic           fault_req_reg;
   logic           flag_set;
   logic           drain_set;
   logic           was_busy_reg;
   logic           take;
   logic           wb_hit;
   logic           is_copro;

   // true when a word belongs to the co-processor command space
   function automatic logic copro_word(input logic [31:0] w);
      return w[31:8] == `GCS_COPRO_TAG;
   endfunction : copro_word

   // fixed hardware resources held back from the host
   assign reserved_handle = `GCS_RESERVED_HANDLE;
   assign user_ctx_depth  = `GCS_USER_DEPTH;

   assign take     = clk_en && cmd_valid && cmd_ready;
   assign is_copro = copro_word(cmd_data);
   assign wb_hit   = wb_cyc_i && wb_stb_i && !ack_reg;

   // words are taken while fetching, collecting arguments or skipping
   always_comb begin
      case (state_reg)
         ST_FETCH: cmd_ready = 1'b1;
         ST_ARG:   cmd_ready = 1'b1;
         ST_SKIP:  cmd_ready = 1'b1;
         default:  cmd_ready = 1'b0;
      endcase
   end

   // per-widget colour selection; drawing never alters stored state
   always_comb begin
      paint_used   = 1'b1;
      paint_colour = col_reg.cur;
      case (widget)
         W_TEXT, W_NUMBER, W_SPIN: begin
            paint_used = (region == R_LABEL);
         end
         W_SCROLL, W_CALIB: begin
            paint_used   = (region != R_LABEL);
            paint_colour = (region == R_FACE) ? col_reg.fore : col_reg.back;
         end
         W_SLIDER, W_TOGGLE: begin
            case (region)
               R_FACE:  paint_colour = col_reg.fore;
               R_BACK:  paint_colour = col_reg.back;
               default: paint_colour = col_reg.cur;
            endcase
         end
         W_GAUGE, W_PROGRESS: begin
            paint_used   = (region != R_FACE);
            paint_colour = (region == R_BACK) ? col_reg.back : col_reg.cur;
         end
         W_BUTTON, W_KEYS, W_DIAL: begin
            paint_used   = (region != R_BACK);
            paint_colour = (region == R_FACE) ? col_reg.fore : col_reg.cur;
         end
         default: begin
            paint_used = 1'b0;
         end
      endcase
   end

   // command sequencer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg   <= ST_FETCH;
         op_reg      <= 32'h0;
         arg_idx_reg <= 2'h0;
         skip_reg    <= 32'h0;
      end else if (clk_en) begin
         case (state_reg)
            ST_FETCH: begin
               if (fault_req_reg) begin
                  state_reg <= ST_FAULT;
               end else if (take) begin
                  op_reg      <= cmd_data;
                  arg_idx_reg <= 2'h0;
                  if (cmd_data == `GCS_OP_LIST_START) begin
                     state_reg <= ST_WAIT;
                  end else if (cmd_data == `GCS_OP_FAULT) begin
                     state_reg <= ST_FAULT;
                  end else if (is_copro && cmd_data != `GCS_OP_LIST_SWAP
                               && cmd_data != `GCS_OP_RESTORE_DEF
                               && cmd_data != `GCS_OP_SPINNER
                               && cmd_data != `GCS_OP_STOP
                               && cmd_data != `GCS_OP_IDENTITY) begin
                     state_reg <= ST_ARG;
                  end
               end
            end
            ST_ARG: begin
               if (take) begin
                  arg_idx_reg <= arg_idx_reg + 2'h1;
                  if (op_reg == `GCS_OP_MEMWRITE && arg_idx_reg == 2'h1) begin
                     // byte count rounded up to whole words
                     skip_reg  <= (cmd_data + 32'h3) >> 2;
                     state_reg <= (cmd_data == 32'h0) ? ST_FETCH : ST_SKIP;
                  end else if (op_reg != `GCS_OP_MEMWRITE) begin
                     state_reg <= ST_FETCH;
                  end
               end
            end
            ST_SKIP: begin
               if (take) begin
                  skip_reg <= skip_reg - 32'h1;
                  if (skip_reg == 32'h1) begin
                     state_reg <= ST_FETCH;
                  end
               end
            end
            ST_WAIT: begin
               if (scan_done) begin
                  state_reg <= ST_FETCH;
               end
            end
            ST_FAULT: begin
               state_reg <= ST_FAULT;
            end
            default: begin
               state_reg <= ST_FETCH;
            end
         endcase
      end
   end

   // graphics state; start and swap leave it alone
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         col_reg   <= '{fore: `GCS_DEF_FORE, back: `GCS_DEF_BACK,
                        cur: `GCS_DEF_CUR};
         high_reg  <= `GCS_DEF_HIGH;
         spin_reg  <= 1'b0;
         track_reg <= 8'h0;
         mat_a_reg <= `GCS_DEF_ONE;
         mat_e_reg <= `GCS_DEF_ONE;
      end else if (clk_en) begin
         if (take && state_reg == ST_FETCH) begin
            if (cmd_data == `GCS_OP_RESTORE_DEF) begin
               col_reg   <= '{fore: `GCS_DEF_FORE, back: `GCS_DEF_BACK,
                              cur: `GCS_DEF_CUR};
               high_reg  <= `GCS_DEF_HIGH;
               spin_reg  <= 1'b0;
               track_reg <= 8'h0;
               mat_a_reg <= `GCS_DEF_ONE;
               mat_e_reg <= `GCS_DEF_ONE;
            end else if (cmd_data == `GCS_OP_SPINNER) begin
               spin_reg <= 1'b1;
            end else if (cmd_data == `GCS_OP_STOP) begin
               spin_reg <= 1'b0;
            end else if (cmd_data == `GCS_OP_IDENTITY) begin
               mat_a_reg <= `GCS_DEF_ONE;
               mat_e_reg <= `GCS_DEF_ONE;
            end else if (cmd_data[31:24] == `GCS_CUR_COLOUR_TAG) begin
               col_reg.cur <= cmd_data[23:0];
            end
         end else if (take && state_reg == ST_ARG && arg_idx_reg == 2'h0) begin
            case (op_reg)
               `GCS_OP_BACK_COLOUR: col_reg.back <= cmd_data[23:0];
               `GCS_OP_FORE_COLOUR: col_reg.fore <= cmd_data[23:0];
               `GCS_OP_HIGH_COLOUR: high_reg     <= cmd_data[23:0];
               `GCS_OP_TRACKER:     track_reg    <= track_reg | 8'h01;
               default:             high_reg     <= high_reg;
            endcase
         end
      end
   end

   // list writer: copies plain words and handles the offset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ofs_reg    <= '0;
         list_we    <= 1'b0;
         list_addr  <= '0;
         list_wdata <= 32'h0;
         swap_req   <= 1'b0;
      end else if (clk_en) begin
         list_we  <= 1'b0;
         swap_req <= 1'b0;
         if (state_reg == ST_WAIT && scan_done) begin
            ofs_reg <= '0;
         end
         if (take && state_reg == ST_FETCH && !is_copro) begin
            list_we    <= 1'b1;
            list_addr  <= ofs_reg;
            list_wdata <= cmd_data;
            ofs_reg    <= ofs_reg + 1'b1;
         end
         if (take && state_reg == ST_FETCH && cmd_data == `GCS_OP_LIST_SWAP) begin
            swap_req <= 1'b1;
         end
      end
   end

   // list overflow becomes a fault
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_req_reg <= 1'b0;
      end else if (clk_en) begin
         if (take && state_reg == ST_FETCH && !is_copro && &ofs_reg) begin
            fault_req_reg <= 1'b1;
         end
      end
   end

   // millisecond timer for the raise-flag command
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_on_reg <= 1'b0;
         ms_left_reg  <= 32'h0;
         tick_reg     <= 32'h0;
         flag_set     <= 1'b0;
      end else if (clk_en) begin
         flag_set <= 1'b0;
         if (take && state_reg == ST_ARG && op_reg == `GCS_OP_RAISE_FLAG) begin
            flag_set     <= (cmd_data == 32'h0);
            timer_on_reg <= (cmd_data != 32'h0);
            ms_left_reg  <= cmd_data;
            tick_reg     <= 32'h0;
         end else if (take && state_reg == ST_FETCH && cmd_data == `GCS_OP_RESTORE_DEF) begin
            timer_on_reg <= 1'b0;
         end else if (timer_on_reg) begin
            if (tick_reg == 32'(MS_CYCLES - 1)) begin
               tick_reg    <= 32'h0;
               ms_left_reg <= ms_left_reg - 32'h1;
               if (ms_left_reg == 32'h1) begin
                  timer_on_reg <= 1'b0;
                  flag_set     <= 1'b1;
               end
            end else begin
               tick_reg <= tick_reg + 32'h1;
            end
         end
      end
   end

   // drained event: queue emptied after work, or fault
   assign drain_set = (state_reg == ST_FAULT && read_ptr_reg != `GCS_FAULT_PTR)
                      || (was_busy_reg && fifo_empty && state_reg == ST_FETCH);

   // read pointer and busy tracking
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_ptr_reg <= 12'h0;
         was_busy_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == ST_FAULT) begin
            read_ptr_reg <= `GCS_FAULT_PTR;
         end else if (take) begin
            read_ptr_reg <= read_ptr_reg + 12'h4;
         end
         if (take) begin
            was_busy_reg <= 1'b1;
         end else if (fifo_empty && state_reg == ST_FETCH) begin
            was_busy_reg <= 1'b0;
         end
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= 2'h0;
         enable_reg <= 2'h0;
      end else if (clk_en) begin
         if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `GCS_REG_CLEAR) begin
            status_reg <= status_reg & ~wb_dat_i[1:0];
         end
         if (flag_set) begin
            status_reg[`GCS_IRQ_FLAG_BIT] <= 1'b1;
         end
         if (drain_set) begin
            status_reg[`GCS_IRQ_DRAIN_BIT] <= 1'b1;
         end
         if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `GCS_REG_ENABLE) begin
            enable_reg <= wb_dat_i[1:0];
         end
      end
   end

   assign irq = |(status_reg & enable_reg);

   // wishbone: one-cycle registered answer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0;
      end else if (clk_en) begin
         ack_reg <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               `GCS_REG_STATUS:   rdat_reg <= {30'h0, status_reg};
               `GCS_REG_ENABLE:   rdat_reg <= {30'h0, enable_reg};
               `GCS_REG_LIST_OFS: rdat_reg <= 32'(ofs_reg);
               `GCS_REG_READ_PTR: rdat_reg <= {20'h0, read_ptr_reg};
               `GCS_REG_BACK:     rdat_reg <= {8'h0, col_reg.back};
               `GCS_REG_FORE:     rdat_reg <= {8'h0, col_reg.fore};
               `GCS_REG_HIGH:     rdat_reg <= {8'h0, high_reg};
               `GCS_REG_CUR:      rdat_reg <= {8'h0, col_reg.cur};
               `GCS_REG_MISC:     rdat_reg <= {track_reg, 7'h0, spin_reg,
                                               7'h0, timer_on_reg, 8'h0};
               `GCS_REG_FAULT:    rdat_reg <= {31'h0, state_reg == ST_FAULT};
               default:           rdat_reg <= 32'h0;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

endmodule : gcs_engine

// >>> pkg/gcs_params.svh
// constants for the co-processor state and command block
// assumes a 32-bit command word stream and a 32-bit wishbone slave
`ifndef GCS_PARAMS_SVH
`define GCS_PARAMS_SVH

// command words
`define GCS_OP_LIST_START    32'hFFFFFF00
`define GCS_OP_LIST_SWAP     32'hFFFFFF01
`define GCS_OP_RAISE_FLAG    32'hFFFFFF02
`define GCS_OP_RESTORE_DEF   32'hFFFFFF32
`define GCS_OP_BACK_COLOUR   32'hFFFFFF09
`define GCS_OP_FORE_COLOUR   32'hFFFFFF0A
`define GCS_OP_HIGH_COLOUR   32'hFFFFFF34
`define GCS_OP_SPINNER       32'hFFFFFF16
`define GCS_OP_STOP          32'hFFFFFF17
`define GCS_OP_TRACKER       32'hFFFFFF2C
`define GCS_OP_IDENTITY      32'hFFFFFF26
`define GCS_OP_MEMWRITE      32'hFFFFFF1A
`define GCS_OP_FAULT         32'hFFFFFFFF
// current colour display-list op: top byte 0x04
`define GCS_CUR_COLOUR_TAG   8'h04
`define GCS_COPRO_TAG        24'hFFFFFF

// reset defaults
`define GCS_DEF_BACK         24'h002040
`define GCS_DEF_FORE         24'h003870
`define GCS_DEF_HIGH         24'hFFFFFF
`define GCS_DEF_CUR          24'hFFFFFF
`define GCS_DEF_ONE          32'h00010000
`define GCS_RESERVED_HANDLE  5'h0F
`define GCS_USER_DEPTH       4'h3
`define GCS_FAULT_PTR        12'hFFF

// register offsets (bytes)
`define GCS_REG_STATUS       8'h00
`define GCS_REG_CLEAR        8'h04
`define GCS_REG_ENABLE       8'h08
`define GCS_REG_LIST_OFS     8'h0C
`define GCS_REG_READ_PTR     8'h10
`define GCS_REG_BACK         8'h14
`define GCS_REG_FORE         8'h18
`define GCS_REG_HIGH         8'h1C
`define GCS_REG_CUR          8'h20
`define GCS_REG_MISC         8'h24
`define GCS_REG_FAULT        8'h28

// status bit positions
`define GCS_IRQ_FLAG_BIT     0
`define GCS_IRQ_DRAIN_BIT    1

// timing
`define GCS_CLK_HZ           10000000
`define GCS_MS_NS            1000000
`define GCS_CLK_NS           100
`define GCS_MS_CYCLES        (`GCS_MS_NS / `GCS_CLK_NS)
`endif

// >>> pkg/gcs_pkg.sv
// types for the co-processor state and command block
// assumes gcs_params.svh supplies the numeric constants
package gcs_pkg;
   typedef struct packed {
      logic [23:0] fore;
      logic [23:0] back;
      logic [23:0] cur;
   } gcs_colours_t;

   typedef enum logic [3:0] {
      W_TEXT, W_BUTTON, W_GAUGE, W_KEYS, W_PROGRESS, W_SCROLL, W_SLIDER,
      W_DIAL, W_TOGGLE, W_NUMBER, W_CALIB, W_SPIN
   } gcs_widget_t;

   typedef enum logic [2:0] {
      R_FACE, R_BACK, R_LABEL
   } gcs_region_t;

   typedef enum logic [5:0] {
      ST_FETCH = 6'b000001,
      ST_ARG   = 6'b000010,
      ST_WAIT  = 6'b000100,
      ST_SKIP  = 6'b001000,
      ST_FAULT = 6'b010000,
      ST_WRITE = 6'b100000
   } gcs_state_t;
endpackage : gcs_pkg

// >>> test/gcs_engine_asserts.sv
// port checker for the co-processor state and command block
// assumes it is bound onto gcs_engine, one clock domain
`timescale 1ns/10ps
`include "gcs_params.svh"
module gcs_engine_asserts
   import gcs_pkg::*;
(
   input wire logic        ref_clk,         // clock
   input wire logic        rst_b,           // reset, active low
   input wire logic        clk_en,          // run enable
   input wire logic [31:0] cmd_data,        // command word
   input wire logic        cmd_valid,       // word present
   input wire logic        cmd_ready,       // word taken
   input wire logic        swap_req,        // swap pulse
   input wire gcs_widget_t widget,          // widget queried
   input wire gcs_region_t region,          // region queried
   input wire logic        paint_used,      // region coloured
   input wire logic [4:0]  reserved_handle, // engine handle
   input wire logic [3:0]  user_ctx_depth,  // host save depth
   input wire logic        wb_cyc_i,        // bus cycle
   input wire logic        wb_stb_i,        // bus strobe
   input wire logic        wb_ack_o         // bus acknowledge
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // a given word taken from the stream
   sequence s_take(logic [31:0] w);
      cmd_valid && cmd_ready && clk_en && cmd_data == w;
   endsequence
   // stream held shut for eight cycles
   sequence s_shut;
      !cmd_ready [*8];
   endsequence
   a_fixed_consts: assert property (reserved_handle == 5'h0F && user_ctx_depth == 4'h3)
      else $error("reserved handle or host depth wrong");
   a_start_stall: assert property (s_take(`GCS_OP_LIST_START) |=> !cmd_ready)
      else $error("stream not stalled after start");
   a_swap_pulse: assert property ($rose(swap_req) && clk_en |=> !swap_req)
      else $error("swap request longer than one cycle");
   a_fault_halt: assert property (s_take(`GCS_OP_FAULT) |=> s_shut)
      else $error("stream accepted after fault");
   a_back_only: assert property (region == R_BACK && paint_used |->
      widget inside {W_GAUGE, W_PROGRESS, W_SCROLL, W_SLIDER, W_TOGGLE, W_CALIB})
      else $error("background on widget without one");
   a_scroll_nocur: assert property (widget inside {W_SCROLL, W_CALIB} && region == R_LABEL
      |-> !paint_used)
      else $error("current colour used on scroll or calibrate");
   a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
      else $error("ack not one cycle after request");
endmodule : gcs_engine_asserts

bind gcs_engine gcs_engine_asserts gcs_engine_asserts_inst (.ref_clk(ref_clk),
   .rst_b(rst_b), .clk_en(clk_en), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .swap_req(swap_req), .widget(widget), .region(region),
   .paint_used(paint_used), .reserved_handle(reserved_handle),
   .user_ctx_depth(user_ctx_depth), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o));

// >>> test/gcs_host.sv
// host model: writes command words to the engine one at a time
// assumes a word is taken on an edge where valid and ready are high
`timescale 1ns/10ps
module gcs_host (
   input  wire logic  ref_clk,    // clock
   output logic [31:0] cmd_data,  // command word
   output logic       cmd_valid,  // word present
   input  wire logic  cmd_ready,  // engine takes word
   output logic       fifo_empty  // nothing queued
);
   // idle at time zero
   initial begin
      cmd_data = 32'h0;
      cmd_valid = 1'b0;
      fifo_empty = 1'b1;
   end
   // whole four-byte words, held until taken, inverted after release
   task automatic send(input logic [31:0] w);
      @(posedge ref_clk);
      cmd_data <= w;
      cmd_valid <= 1'b1;
      fifo_empty <= 1'b0;
      do @(posedge ref_clk); while (cmd_ready !== 1'b1);
      cmd_data <= ~w;
      cmd_valid <= 1'b0;
      fifo_empty <= 1'b1;
   endtask : send
endmodule : gcs_host

// >>> test/graphics_coprocessor_state_cmds_test.sv
// self-checking bench for the co-processor state and command block
// assumes gcs_engine, gcs_host and the bound checker are compiled alongside
`timescale 1ns/10ps
module graphics_coprocessor_state_cmds_test;
   import gcs_pkg::*;
   localparam logic [7:0] DA[5] = '{8'h14, 8'h18, 8'h1C, 8'h24, 8'h3C};
   localparam logic [31:0] DV[5] = '{32'h2040, 32'h3870, 32'hFFFFFF, 32'h0, 32'h0};
   localparam gcs_widget_t PW[12] = '{W_BUTTON, W_DIAL, W_GAUGE, W_BUTTON, W_SCROLL,
      W_SCROLL, W_SCROLL, W_TEXT, W_SLIDER, W_TOGGLE, W_CALIB, W_NUMBER};
   localparam gcs_region_t PR[12] = '{R_FACE, R_FACE, R_BACK, R_BACK, R_FACE, R_BACK,
      R_LABEL, R_LABEL, R_LABEL, R_BACK, R_LABEL, R_LABEL};
   localparam logic [1:0] PS[12] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2,
      2'h0, 2'h3, 2'h3, 2'h2, 2'h0, 2'h3};
   logic ref_clk, rst_b, clk_en, scan_done, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
   logic cmd_valid, cmd_ready, fifo_empty, list_we, swap_req, paint_used;
   logic [31:0] cmd_data, list_wdata, wb_dat_i, wb_dat_o, seed;
   logic [23:0] bk, fg, e, paint_colour;
   logic [10:0] list_addr, ofs;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [63:0] rq[$];
   logic [63:0] rn;
   logic [42:0] lq[$];
   gcs_widget_t widget;
   gcs_region_t region;
   int failures, checked, k;
   gcs_engine #(.MS_CYCLES(10)) gcs_engine_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .clk_en(clk_en), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .fifo_empty(fifo_empty), .list_addr(list_addr), .list_wdata(list_wdata),
      .list_we(list_we), .scan_done(scan_done), .swap_req(swap_req), .widget(widget),
      .region(region), .paint_colour(paint_colour), .paint_used(paint_used),
      .reserved_handle(), .user_ctx_depth(), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
   gcs_host gcs_host_inst (.ref_clk(ref_clk), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .fifo_empty(fifo_empty));
   // 100 ns clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   // one classic cycle; a read notes its masked expectation
   task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, m);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      if (!we) rq.push_back({m, d});
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic cw(input logic [31:0] x);
      gcs_host_inst.send(x);
   endtask : cw
   // word that lands in the list at the running offset
   task automatic put(input logic [31:0] x);
      lq.push_back({ofs, x});
      ofs++;
      cw(x);
   endtask : put
   task automatic flag_irq(input logic x);
      @(posedge ref_clk);
      chk("irq", {31'h0, irq}, {31'h0, x});
   endtask : flag_irq
   task automatic give_verdict;
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   // compares each read answer and list write with the oldest note
   always @(posedge ref_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         rn = rq.pop_front();
         chk("wb_dat_o", wb_dat_o & rn[63:32], rn[31:0]);
      end
      if (list_we === 1'b1 && lq.size() == 0)
         chk("list_we", 32'h1, 32'h0);
      else if (list_we === 1'b1)
         chk("list_write", {list_addr, list_wdata}, lq.pop_front());
   end
   // cuts a hang short
   initial begin
      #2000000;
      failures++;
      give_verdict();
   end
   // main sequence
   initial begin
      {rst_b, scan_done, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h0;
      {clk_en, wb_sel_i, wb_adr_i, wb_dat_i, ofs} = {1'b1, 4'hF, 51'h0};
      widget = W_TEXT;
      region = R_FACE;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      seed = $urandom(80779);
      foreach (DA[i]) wb(DA[i], 1'b0, DV[i], '1);
      bk = 24'($urandom());
      fg = 24'($urandom());
      cw(32'hFFFFFF09);
      cw({8'h00, bk});
      cw(32'hFFFFFF0A);
      cw({8'h00, fg});
      put({8'h04, seed[23:0]});
      for (k = 0; k < 12; k++) begin
         widget <= PW[k];
         region <= PR[k];
         e = PS[k] == 2'h1 ? fg : PS[k] == 2'h2 ? bk : seed[23:0];
         @(posedge ref_clk);
         chk("paint_used", {31'h0, paint_used}, {31'h0, PS[k] != 2'h0});
         if (PS[k] != 2'h0) chk("paint_colour", {8'h0, paint_colour}, {8'h0, e});
      end
      for (k = 0; k < 3; k++) put({8'h01, 24'($urandom())});
      // memory write of five bytes: data and pad look like commands
      cw(32'hFFFFFF1A);
      cw(32'h0);
      cw(32'h5);
      cw(32'hFFFFFF01);
      cw(32'hFFFFFF32);
      put(32'h015A5A5A);
      cw(32'hFFFFFF01);
      k = 0;
      repeat (4) @(posedge ref_clk) k += int'(swap_req === 1'b1);
      chk("swap_req", k, 32'h1);
      wb(8'h0C, 1'b0, {21'h0, ofs}, 32'h7FF);
      wb(8'h18, 1'b0, {8'h00, fg}, '1);
      cw(32'hFFFFFF00);
      repeat (3) @(posedge ref_clk);
      chk("cmd_ready", {31'h0, cmd_ready}, 32'h0);
      scan_done <= 1'b1;
      @(posedge ref_clk) scan_done <= 1'b0;
      ofs = 11'h000;
      put(32'h01C3C3C3);
      wb(8'h14, 1'b0, {8'h00, bk}, '1);
      // flag with no delay, then with two milliseconds, then masked
      wb(8'h08, 1'b1, 32'h1, '0);
      cw(32'hFFFFFF02);
      cw(32'h0);
      repeat (2) @(posedge ref_clk);
      flag_irq(1'b1);
      wb(8'h00, 1'b0, 32'h1, 32'h1);
      wb(8'h04, 1'b1, 32'h1, '0);
      flag_irq(1'b0);
      cw(32'hFFFFFF02);
      cw(32'h2);
      repeat (20) @(posedge ref_clk);
      flag_irq(1'b0);
      flag_irq(1'b1);
      wb(8'h08, 1'b1, 32'h0, '0);
      flag_irq(1'b0);
      // change highlight, spinner, tracker and timer so restore has work
      e = 24'($urandom());
      cw(32'hFFFFFF34);
      cw({8'h00, e});
      cw(32'hFFFFFF16);
      cw(32'hFFFFFF2C);
      cw(32'h0);
      cw(32'hFFFFFF02);
      cw(32'h5);
      wb(8'h1C, 1'b0, {8'h00, e}, '1);
      wb(8'h24, 1'b0, 32'h01010100, '1);
      cw(32'hFFFFFF32);
      foreach (DA[i]) wb(DA[i], 1'b0, DV[i], '1);
      cw(32'hFFFFFF09);
      cw({8'h00, e});
      cw(32'hFFFFFFFF);
      wb(8'h10, 1'b0, 32'hFFF, 32'hFFF);
      wb(8'h00, 1'b0, 32'h2, 32'h2);
      chk("cmd_ready", {31'h0, cmd_ready}, 32'h0);
      // mid-run reset leaves the fault and reloads defaults
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      wb(8'h14, 1'b0, 32'h2040, '1);
      wb(8'h28, 1'b0, 32'h0, '1);
      chk("cmd_ready", {31'h0, cmd_ready}, 32'h1);
      give_verdict();
   end
endmodule : graphics_coprocessor_state_cmds_test
